/* File: pbr_defines.vh */
// Offsets, field positions, reset values and timing counts of the basic management registers
`ifndef PBR_DEFINES_VH
`define PBR_DEFINES_VH

// Register addresses on the management port
`define PBR_ADDR_W            5
`define PBR_ADDR_CTL          5'h00
`define PBR_ADDR_STS          5'h01
`define PBR_ADDR_IDH          5'h02
`define PBR_ADDR_IDL          5'h03
`define PBR_ADDR_GIGABIT_STATUS_PRESENT      5'h0F

// Control register fields
`define PBR_CTL_SOFT_RST      15
`define PBR_CTL_SPEED_LOW     13
`define PBR_CTL_NEG_EN        12
`define PBR_CTL_LOW_POWER     11
`define PBR_CTL_ISOLATE       10
`define PBR_CTL_NEG_RESTART   9
`define PBR_CTL_DUPLEX        8
`define PBR_CTL_COL_TEST      7
`define PBR_CTL_SPEED_HIGH    6
`define PBR_CTL_RESET         16'h1140

// Status register fields
`define PBR_STS_FAST_FD       14
`define PBR_STS_FAST_HD       13
`define PBR_STS_LEGACY_FD     12
`define PBR_STS_LEGACY_HD     11
`define PBR_STS_GIG_PRESENT   8
`define PBR_STS_SHORT_PRE     6
`define PBR_STS_NEG_DONE      5
`define PBR_STS_REMOTE_FAULT  4
`define PBR_STS_NEG_ABILITY   3
`define PBR_STS_LINK          2
`define PBR_STS_JABBER        1
`define PBR_STS_EXT_SET       0
`define PBR_STS_RESET         16'h7949

// Forced speed codes
`define PBR_SPEED_10          2'h0
`define PBR_SPEED_100         2'h1
`define PBR_SPEED_1000        2'h2
`define PBR_SPEED_RSVD        2'h3

// Soft reset duration
`define PBR_CLK_KHZ           10000
`define PBR_SOFT_RST_NS       1000
`define PBR_SOFT_RST_CYC      ((`PBR_SOFT_RST_NS * `PBR_CLK_KHZ + 999999) / 1000000)
`define PBR_CNT_W             4

`endif

/* File: pbr_regs.v */
// Basic control, status and identifier registers of the PHY management block
//
// How it works
// - Control bit 12 negotiation enable, resets 1
// - Control bit 11 mirrors low power state
// - Control bit 10 isolates MAC-side pins
// - Bit 9 restarts negotiation, then self-clears
// - Control bit 8 full duplex, resets 1
// - Control bit 7 enables collision signal test
// - Bit 6 read-only upper speed bit, 1
// - Speed code from bits 6,13 when forced
// - Bit 15 resets management logic, self-clears
// - Status bits 14..11 ability flags read 1
// - Status bit 8 gigabit status present
// - Status bit 6 short preamble accepted
// - Status bit 5 negotiation done
// - Status bit 4 remote fault, clear on read
// - Status bit 3 negotiation ability reads 1
// - Status bit 2 latches low on loss
// - Status bit 1 jabber, clear on read
// - Status bit 0 extended set present
// - Identifier holds vendor code, model, revision
// - Identifier may optionally read all zero
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`include "pbr_defines.vh"

module pbr_regs #(
  parameter [23:0] VENDOR_CODE  = 24'h00A5C3,  // Arbitrary value
  parameter [5:0]  MODEL_NUMBER = 6'h15,       // Arbitrary value
  parameter [3:0]  REVISION     = 4'h2,        // Arbitrary value
  parameter        ID_AS_ZERO   = 1'b0         // Return zero identifier
) (
  input  wire                    ref_clk,               // 10 MHz clock
  input  wire                    resetn,                // Async reset, active low
  input  wire [`PBR_ADDR_W-1:0]  reg_addr,              // Register address
  input  wire [15:0]             reg_wdata,             // Write data
  input  wire                    reg_wr,                // Write strobe
  input  wire                    reg_rd,                // Read strobe
  output reg  [15:0]             reg_rdata,             // Read data, cycle after strobe
  input  wire                    low_power_state,       // Low-power state active
  input  wire                    negotiation_done_in,   // Negotiation complete
  input  wire                    link_up_in,            // Current link state
  input  wire                    remote_fault_in,       // Remote fault seen
  input  wire                    jabber_in,             // Jabber seen
  output wire                    negotiation_enable,    // Negotiation on
  output wire                    negotiation_restart,   // Restart pulse
  output wire                    mac_isolate,           // Isolate MAC pins
  output wire                    full_duplex,           // Full duplex select
  output wire                    collision_signal_test, // Collision test on
  output wire [1:0]              forced_speed,          // Forced speed code
  output wire                    forced_speed_valid,    // Forced speed in use
  output wire                    mgmt_soft_reset        // Management reset active
);

  // Register index compare, shared by the read and write paths
  function addr_is;
    input [`PBR_ADDR_W-1:0] a;
    input [`PBR_ADDR_W-1:0] ref_a;
    begin
      addr_is = (a == ref_a);
    end
  endfunction

  // Reset release through two flops
  reg rst_s1_q;
  reg rst_s2_q;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire rst_n = rst_s2_q;

  // Status inputs come from the PCS side, so each passes two flops
  reg [4:0] sync1_q;
  reg [4:0] sync2_q;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end else begin
      sync1_q <= {low_power_state, negotiation_done_in, link_up_in,
                  remote_fault_in, jabber_in};
      sync2_q <= sync1_q;
    end
  end
  wire lp_s   = sync2_q[4];
  wire done_s = sync2_q[3];
  wire link_s = sync2_q[2];
  wire rf_s   = sync2_q[1];
  wire jab_s  = sync2_q[0];

  wire wr_ctl = reg_wr && addr_is(reg_addr, `PBR_ADDR_CTL);
  wire rd_sts = reg_rd && addr_is(reg_addr, `PBR_ADDR_STS);

  // Control fields
  reg                   neg_en_q;
  reg                   neg_en_d;
  reg                   isolate_q;
  reg                   isolate_d;
  reg                   restart_q;
  reg                   restart_d;
  reg                   duplex_q;
  reg                   duplex_d;
  reg                   col_test_q;
  reg                   col_test_d;
  reg                   speed_low_q;
  reg                   speed_low_d;
  reg                   soft_rst_q;
  reg                   soft_rst_d;
  reg [`PBR_CNT_W-1:0]  soft_cnt_q;
  reg [`PBR_CNT_W-1:0]  soft_cnt_d;

  // Soft reset length, cut to the counter width on purpose
  localparam integer          SOFT_CYC_I = `PBR_SOFT_RST_CYC;
  localparam [`PBR_CNT_W-1:0] SOFT_CYC   = SOFT_CYC_I[`PBR_CNT_W-1:0];
  localparam [`PBR_CNT_W-1:0] CNT_ONE    = {{(`PBR_CNT_W-1){1'b0}}, 1'b1};

  // The write that asks for a soft reset loads defaults, not its own data,
  // so no field glitches to a written value for one cycle
  wire soft_req = wr_ctl && reg_wdata[`PBR_CTL_SOFT_RST];

  always @* begin
    neg_en_d    = neg_en_q;
    isolate_d   = isolate_q;
    restart_d   = 1'b0;
    duplex_d    = duplex_q;
    col_test_d  = col_test_q;
    speed_low_d = speed_low_q;
    soft_rst_d  = soft_rst_q;
    soft_cnt_d  = soft_cnt_q;
    if (soft_rst_q || soft_req) begin
      // Defaults held throughout; writes during soft reset are dropped
      neg_en_d    = 1'b1;
      isolate_d   = 1'b0;
      duplex_d    = 1'b1;
      col_test_d  = 1'b0;
      speed_low_d = 1'b0;
    end else if (wr_ctl) begin
      neg_en_d    = reg_wdata[`PBR_CTL_NEG_EN];
      isolate_d   = reg_wdata[`PBR_CTL_ISOLATE];
      restart_d   = reg_wdata[`PBR_CTL_NEG_RESTART];
      duplex_d    = reg_wdata[`PBR_CTL_DUPLEX];
      col_test_d  = reg_wdata[`PBR_CTL_COL_TEST];
      speed_low_d = reg_wdata[`PBR_CTL_SPEED_LOW];
    end
    if (soft_rst_q) begin
      if (soft_cnt_q == CNT_ONE) begin
        soft_rst_d = 1'b0;
        soft_cnt_d = {`PBR_CNT_W{1'b0}};
      end else begin
        soft_cnt_d = soft_cnt_q - CNT_ONE;
      end
    end else if (soft_req) begin
      soft_rst_d = 1'b1;
      soft_cnt_d = SOFT_CYC;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      neg_en_q    <= 1'b1;
      isolate_q   <= 1'b0;
      restart_q   <= 1'b0;
      duplex_q    <= 1'b1;
      col_test_q  <= 1'b0;
      speed_low_q <= 1'b0;
      soft_rst_q  <= 1'b0;
      soft_cnt_q  <= {`PBR_CNT_W{1'b0}};
    end else begin
      neg_en_q    <= neg_en_d;
      isolate_q   <= isolate_d;
      restart_q   <= restart_d;
      duplex_q    <= duplex_d;
      col_test_q  <= col_test_d;
      speed_low_q <= speed_low_d;
      soft_rst_q  <= soft_rst_d;
      soft_cnt_q  <= soft_cnt_d;
    end
  end

  // Latched status flags; an event in the read cycle survives the clear
  reg link_lat_q;
  reg link_lat_d;
  reg rf_lat_q;
  reg rf_lat_d;
  reg jab_lat_q;
  reg jab_lat_d;

  always @* begin
    link_lat_d = link_lat_q;
    rf_lat_d   = rf_lat_q;
    jab_lat_d  = jab_lat_q;
    if (!link_s) begin
      link_lat_d = 1'b0;
    end else if (rd_sts) begin
      link_lat_d = 1'b1;
    end
    if (rf_s) begin
      rf_lat_d = 1'b1;
    end else if (rd_sts) begin
      rf_lat_d = 1'b0;
    end
    if (jab_s) begin
      jab_lat_d = 1'b1;
    end else if (rd_sts) begin
      jab_lat_d = 1'b0;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_lat_q <= 1'b0;
      rf_lat_q   <= 1'b0;
      jab_lat_q  <= 1'b0;
    end else begin
      link_lat_q <= link_lat_d;
      rf_lat_q   <= rf_lat_d;
      jab_lat_q  <= jab_lat_d;
    end
  end

  // Read images; unlisted control bits stay zero, status bits start from the reset value
  reg [15:0] ctl_img;
  reg [15:0] sts_img;
  always @* begin
    ctl_img = 16'h0000;
    ctl_img[`PBR_CTL_SOFT_RST]    = soft_rst_q;
    ctl_img[`PBR_CTL_SPEED_LOW]   = speed_low_q;
    ctl_img[`PBR_CTL_NEG_EN]      = neg_en_q;
    ctl_img[`PBR_CTL_LOW_POWER]   = lp_s;
    ctl_img[`PBR_CTL_ISOLATE]     = isolate_q;
    ctl_img[`PBR_CTL_NEG_RESTART] = restart_q;
    ctl_img[`PBR_CTL_DUPLEX]      = duplex_q;
    ctl_img[`PBR_CTL_COL_TEST]    = col_test_q;
    ctl_img[`PBR_CTL_SPEED_HIGH]  = 1'b1;
    // Fixed ability bits
    sts_img = `PBR_STS_RESET;
    sts_img[`PBR_STS_NEG_DONE]     = done_s;
    sts_img[`PBR_STS_REMOTE_FAULT] = rf_lat_q;
    sts_img[`PBR_STS_LINK]         = link_lat_q;
    sts_img[`PBR_STS_JABBER]       = jab_lat_q;
  end

  wire [31:0] id_word = ID_AS_ZERO ? 32'h00000000 :
                        {VENDOR_CODE[21:0], MODEL_NUMBER, REVISION};

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (addr_is(reg_addr, `PBR_ADDR_CTL)) begin
        reg_rdata <= ctl_img;
      end else if (addr_is(reg_addr, `PBR_ADDR_STS)) begin
        reg_rdata <= sts_img;
      end else if (addr_is(reg_addr, `PBR_ADDR_IDH)) begin
        reg_rdata <= id_word[31:16];
      end else if (addr_is(reg_addr, `PBR_ADDR_IDL)) begin
        reg_rdata <= id_word[15:0];
      end else begin
        reg_rdata <= 16'h0000;
      end
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  assign negotiation_enable    = neg_en_q;
  assign negotiation_restart   = restart_q;
  assign mac_isolate           = isolate_q;
  assign full_duplex           = duplex_q;
  assign collision_signal_test = col_test_q;
  // Upper speed bit is fixed, so only the 1000 code or the reserved code occurs
  assign forced_speed          = {1'b1, speed_low_q};
  assign forced_speed_valid    = !neg_en_q && (forced_speed != `PBR_SPEED_RSVD);
  assign mgmt_soft_reset       = soft_rst_q;

endmodule

/* File: pbr_regs_props.sv */
// Port assertions for the basic management registers
`timescale 1ns/1ps
`include "pbr_defines.vh"
module pbr_regs_props #(
  parameter [23:0] VENDOR_CODE = 24'h00A5C3,
  parameter        ID_AS_ZERO  = 1'b0
) (
  input wire        ref_clk,               // Clock
  input wire        resetn,                // Reset, active low
  input wire [4:0]  reg_addr,              // Address
  input wire [15:0] reg_wdata,             // Write data
  input wire        reg_wr,                // Write strobe
  input wire        reg_rd,                // Read strobe
  input wire [15:0] reg_rdata,             // Read data
  input wire        negotiation_enable,    // Negotiation on
  input wire        negotiation_restart,   // Restart pulse
  input wire        mac_isolate,           // Isolate
  input wire        full_duplex,           // Duplex
  input wire        collision_signal_test, // Collision test
  input wire [1:0]  forced_speed,          // Speed code
  input wire        forced_speed_valid,    // Speed in use
  input wire        mgmt_soft_reset        // Soft reset
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Writes in soft reset are refused, so they are left out here
  wire       ctl_wr = reg_wr && reg_addr == `PBR_ADDR_CTL && !mgmt_soft_reset;
  wire [4:0] ctl_o  = {negotiation_enable, forced_speed[0], mac_isolate, full_duplex,
                       collision_signal_test};
  wire [4:0] ctl_w  = {reg_wdata[12], reg_wdata[13], reg_wdata[10], reg_wdata[8], reg_wdata[7]};
  ctl_write_a:
    assert property (ctl_wr && !reg_wdata[15] |=> ctl_o == $past(ctl_w)) else $error("bad ctl");
  ctl_hold_a:
    assert property (!ctl_wr && !mgmt_soft_reset |=> $stable(ctl_o)) else $error("ctl moved");
  restart_pulse_a:
    assert property (ctl_wr && !reg_wdata[15] && reg_wdata[9] |=> negotiation_restart
      ##1 !negotiation_restart) else $error("no restart pulse");
  restart_cause_a:
    assert property (negotiation_restart |-> $past(ctl_wr)) else $error("stray restart");
  soft_reset_a:
    assert property (ctl_wr && reg_wdata[15] |=> (mgmt_soft_reset && !mac_isolate)[*8]
      ##1 mgmt_soft_reset[*2] ##1 !mgmt_soft_reset) else $error("soft reset length");
  speed_map_a:
    assert property (forced_speed[1] && (forced_speed_valid == (!negotiation_enable
      && forced_speed != `PBR_SPEED_RSVD))) else $error("speed code");
  read_idle_a:
    assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("rdata not idle");
  sts_fixed_a:
    assert property (reg_rd && reg_addr == `PBR_ADDR_STS |=> (reg_rdata & 16'hFFC9) == 16'h7949)
      else $error("status fixed bits");
  id_high_a:
    assert property (reg_rd && reg_addr == `PBR_ADDR_IDH |=> reg_rdata == (ID_AS_ZERO ?
      16'h0000 : VENDOR_CODE[21:6])) else $error("id high");
  cover property (ctl_wr && reg_wdata[15]);
  cover property (negotiation_restart);
  cover property (forced_speed_valid);
  cover property (reg_rd && reg_addr == `PBR_ADDR_STS ##1 reg_rdata[1]);
endmodule
bind pbr_regs pbr_regs_props #(.VENDOR_CODE(VENDOR_CODE), .ID_AS_ZERO(ID_AS_ZERO)) chk_u (.*);

/* File: pbr_regs_tb.sv */
// Self-checking bench for the basic management registers
`timescale 1ns/1ps
`include "pbr_defines.vh"
module pbr_regs_tb;
  localparam [23:0] VND = 24'h00A5C3; // Arbitrary value
  localparam [5:0]  MDL = 6'h15;      // Arbitrary value
  localparam [3:0]  REV = 4'h2;       // Arbitrary value
  reg         ref_clk, resetn, reg_wr, reg_rd, lp, done, link, fault, jab;
  reg  [4:0]  reg_addr;
  reg  [15:0] reg_wdata, d;
  reg  [31:0] seed;
  wire [15:0] reg_rdata;
  wire        neg_en, restart, iso, dup, col, fs_v, srst;
  wire [1:0]  fs;
  integer     fail_count, checks, cyc, i, n;
  pbr_regs #(.VENDOR_CODE(VND), .MODEL_NUMBER(MDL), .REVISION(REV), .ID_AS_ZERO(1'b0)) dut_u (
    .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .low_power_state(lp),
    .negotiation_done_in(done), .link_up_in(link), .remote_fault_in(fault), .jabber_in(jab),
    .negotiation_enable(neg_en), .negotiation_restart(restart), .mac_isolate(iso),
    .full_duplex(dup), .collision_signal_test(col), .forced_speed(fs),
    .forced_speed_valid(fs_v), .mgmt_soft_reset(srst));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  function [31:0] xs(input [31:0] s);
    xs = s ^ (s << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  // Control readback: self-clearing bits and reserved bits read 0
  function [15:0] ectl(input [15:0] v);
    ectl = (v & 16'h3580) | 16'h0040 | {4'h0, lp, 11'h000};
  endfunction
  task test_done;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input [15:0] seen, input [15:0] exp, input [8*8:1] nm);
    checks = checks + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("wrong value %0s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input [4:0] a, input [15:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask
  // Read data stand for one cycle only, so sample mid-cycle
  task rc(input [4:0] a, input [15:0] e, input [8*8:1] nm);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    @(negedge ref_clk);
    chk(reg_rdata, e, nm);
    @(posedge ref_clk);
  endtask
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      fail_count = fail_count + 1;
      test_done;
    end
  end
  initial begin
    {resetn, reg_wr, reg_rd, lp, done, link, fault, jab} = 8'h00;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    fail_count = 0;
    checks = 0;
    cyc = 0;
    seed = 32'h0642;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rc(`PBR_ADDR_CTL, `PBR_CTL_RESET, "ctl");
    rc(`PBR_ADDR_STS, `PBR_STS_RESET, "sts");
    rc(`PBR_ADDR_IDH, VND[21:6], "idh");
    rc(`PBR_ADDR_IDL, {VND[5:0], MDL, REV}, "idl");
    rc(5'h07, 16'h0000, "unmap");
    $display("reset values done");
    for (i = 0; i < 24; i = i + 1) begin
      seed = xs(seed);
      d = (i == 0) ? 16'h7FFF : (i == 1) ? 16'h0000 : seed[15:0] & 16'h7FFF;
      lp <= seed[16];
      wr(`PBR_ADDR_CTL, d);
      @(negedge ref_clk);
      chk({neg_en, iso, dup, col}, {d[12], d[10], d[8], d[7]}, "ctl_out");
      chk({15'h0000, restart}, {15'h0000, d[9]}, "restart");
      chk({fs_v, fs}, {(!d[12] && !d[13]), 1'b1, d[13]}, "speed");
      repeat (4) @(posedge ref_clk);
      rc(`PBR_ADDR_CTL, ectl(d), "ctl");
    end
    $display("control writes done");
    {lp, done, link, fault, jab} <= 5'h0F;
    repeat (5) @(posedge ref_clk);
    rc(`PBR_ADDR_STS, 16'h797B, "sts");
    {fault, jab} <= 2'h0;
    repeat (5) @(posedge ref_clk);
    rc(`PBR_ADDR_STS, 16'h797F, "sts");
    rc(`PBR_ADDR_STS, 16'h796D, "sts");
    link <= 1'b0;
    repeat (3) @(posedge ref_clk);
    link <= 1'b1;
    repeat (5) @(posedge ref_clk);
    rc(`PBR_ADDR_STS, 16'h7969, "sts");
    rc(`PBR_ADDR_STS, 16'h796D, "sts");
    $display("status events done");
    wr(`PBR_ADDR_CTL, 16'h8400);
    rc(`PBR_ADDR_CTL, 16'h9140, "srst_ctl");
    wr(`PBR_ADDR_CTL, 16'h0480);
    n = 3;
    @(negedge ref_clk);
    while (srst === 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n = n + 1;
    end
    chk(n[15:0], 16'h000A, "srst_len");
    @(posedge ref_clk);
    rc(`PBR_ADDR_CTL, `PBR_CTL_RESET, "ctl");
    $display("soft reset done");
    test_done;
  end
endmodule
